//--- bench/core_sequencer_model.sv
// Behavioural model of the core sequencer that issues float operations.
`timescale 1ns/100ps
module core_sequencer_model (
  input  wire logic                  clk,
  output float_alu_pkg::alu_req_type op_req,
  output logic                       op_valid,
  output logic                       fix_cmp_valid,
  output logic                       fix_cmp_gt
);
  // ****************************************************************
  // Issue tasks
  // ****************************************************************
  initial begin
    op_valid = 1'b0;
    op_req = '0;
    fix_cmp_valid = 1'b0;
    fix_cmp_gt = 1'b0;
  end
  // Operands are inverted once released, so a stale value can never pass.
  task automatic issue(input float_alu_pkg::op_type op, input logic [39:0] a,
                       input logic [39:0] b);
    begin
      @(posedge clk);
      op_valid <= 1'b1;
      op_req <= '{op: op, a: a, b: b};
      @(posedge clk);
      op_valid <= 1'b0;
      op_req <= '{op: op, a: ~a, b: ~b};
    end
  endtask
  task automatic fix_cmp(input logic gt);
    begin
      @(posedge clk);
      fix_cmp_valid <= 1'b1;
      fix_cmp_gt <= gt;
      @(posedge clk);
      fix_cmp_valid <= 1'b0;
      fix_cmp_gt <= ~gt;
    end
  endtask
endmodule

//--- bench/float_add_sub_compare_alu_tb_top.sv
// Self-checking bench for the float add, subtract and compare slice.
`timescale 1ns/100ps
`include "float_alu_defines.svh"
module float_add_sub_compare_alu_tb_top;
  localparam logic [39:0] ONE   = 40'h3f_8000_0000;
  localparam logic [39:0] TWO   = 40'h40_0000_0000;
  localparam logic [39:0] THREE = 40'h40_4000_0000;
  localparam logic [39:0] NAN   = 40'h7f_c000_0000;
  localparam logic [39:0] INF   = 40'h7f_8000_0000;
  localparam logic [39:0] NINF  = 40'hff_8000_0000;
  localparam logic [39:0] MAXN  = 40'h7f_7fff_ffff;
  localparam logic [39:0] NMAXN = 40'hff_7fff_ffff;
  localparam logic [39:0] ALL1  = 40'hff_ffff_ffff;
  localparam logic [39:0] RND   = 40'h3f_8000_00c0;
  logic                       CLK;
  logic                       RST_N;
  logic                       OP_VALID;
  logic                       FIX_CMP_VALID;
  logic                       FIX_CMP_GT;
  logic                       WR;
  logic                       RD;
  logic                       RESULT_WE;
  logic [7:0]                 ADDR;
  logic [31:0]                WDATA;
  logic [31:0]                RDATA;
  logic [31:0]                STATUS;
  logic [31:0]                STICKY;
  logic [39:0]                RESULT;
  float_alu_pkg::alu_req_type OP_REQ;
  int                         n_mismatch;
  int                         check_count;
  logic [7:0]                 hist;
  logic [31:0]                sk;
  logic [31:0]                rd_val;
  logic [39:0]                last_res;
  logic [39:0]                rnd_exp [4];

  float_add_sub_compare_alu float_add_sub_compare_alu_inst (
    .CLK(CLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_REQ(OP_REQ),
    .FIX_CMP_VALID(FIX_CMP_VALID), .FIX_CMP_GT(FIX_CMP_GT), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RESULT(RESULT),
    .RESULT_WE(RESULT_WE), .STATUS(STATUS), .STICKY(STICKY));
  core_sequencer_model core_sequencer_model_inst (
    .clk(CLK), .op_req(OP_REQ), .op_valid(OP_VALID),
    .fix_cmp_valid(FIX_CMP_VALID), .fix_cmp_gt(FIX_CMP_GT));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    begin
      check_count++;
      if (seen !== exp) begin
        n_mismatch++;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
    end
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    begin
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      check({8'h00, RDATA}, {8'h00, exp});
    end
  endtask
  // Compares leave the result alone, so the last written value is expected.
  task automatic op_chk(input float_alu_pkg::op_type op, input logic [39:0] a,
                        input logic [39:0] b, input logic [39:0] r,
                        input logic [7:0] f);
    begin
      core_sequencer_model_inst.issue(op, a, b);
      #1;
      if (op == float_alu_pkg::OP_CMP) begin
        hist = {~(f[0] | f[2]), hist[7:1]};
        r = last_res;
      end else begin
        sk[0] = sk[0] | f[0];
        if (op != float_alu_pkg::OP_HALF) sk[1] = sk[1] | f[1];
      end
      sk[3] = sk[3] | f[5];
      last_res = r;
      check({39'h0, RESULT_WE}, {39'h0, op != float_alu_pkg::OP_CMP});
      check(RESULT, r);
      check({8'h00, STATUS}, {8'h00, hist, 14'h0001, 2'b00, f});
      check({8'h00, STICKY}, {8'h00, sk});
    end
  endtask
  task wrap_up;
    begin
      if (n_mismatch == 0 && check_count > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    #200000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    RST_N = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h00;
    WDATA = 32'h0;
    n_mismatch = 0;
    check_count = 0;
    hist = 8'h00;
    sk = 32'h4;
    last_res = 40'h0;
    rnd_exp = '{RND, RND, 40'h3f_8000_0100, 40'h3f_8000_0000};
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    reg_rd(`MODE_OFS, 32'h0);
    reg_rd(`STATUS_OFS, 32'h0);
    reg_rd(8'h10, 32'h0);
    reg_wr(`STICKY_OFS, 32'h4);
    reg_rd(`STICKY_OFS, 32'h4);
    op_chk(float_alu_pkg::OP_ADD, ONE, TWO, THREE, 8'h00);
    op_chk(float_alu_pkg::OP_SUB, ONE, TWO, 40'hbf_8000_0000, 8'h04);
    op_chk(float_alu_pkg::OP_ASUB, ONE, TWO, ONE, 8'h00);
    op_chk(float_alu_pkg::OP_HALF, ONE, THREE, TWO, 8'h00);
    op_chk(float_alu_pkg::OP_ADD, MAXN, MAXN, INF, 8'h02);
    op_chk(float_alu_pkg::OP_HALF, MAXN, MAXN, MAXN, 8'h00);
    op_chk(float_alu_pkg::OP_SUB, NMAXN, MAXN, NINF, 8'h06);
    op_chk(float_alu_pkg::OP_ADD, ONE, NAN, ALL1, 8'h20);
    op_chk(float_alu_pkg::OP_ADD, INF, NINF, ALL1, 8'h20);
    op_chk(float_alu_pkg::OP_AADD, NINF, INF, ALL1, 8'h20);
    op_chk(float_alu_pkg::OP_HALF, INF, NINF, ALL1, 8'h20);
    op_chk(float_alu_pkg::OP_SUB, INF, INF, ALL1, 8'h20);
    op_chk(float_alu_pkg::OP_ASUB, NINF, NINF, ALL1, 8'h20);
    op_chk(float_alu_pkg::OP_ADD, 40'h00_4000_0000, 40'h00_4000_0000,
           40'h0, 8'h01);
    op_chk(float_alu_pkg::OP_ASUB, 40'h00_8000_0000, 40'h00_c000_0000,
           40'h0, 8'h01);
    // Bits below the narrow boundary sit above half, so rounding shows.
    for (int m = 0; m < 4; m++) begin
      reg_wr(`MODE_OFS, m);
      op_chk(float_alu_pkg::OP_ADD, RND, 40'h0, rnd_exp[m], 8'h00);
    end
    reg_wr(`MODE_OFS, 32'hff);
    reg_rd(`MODE_OFS, 32'h3);
    reg_wr(`MODE_OFS, 32'h1);
    op_chk(float_alu_pkg::OP_ADD, MAXN, MAXN, MAXN, 8'h02);
    op_chk(float_alu_pkg::OP_AADD, NMAXN, NMAXN, MAXN, 8'h02);
    reg_wr(`MODE_OFS, 32'h0);
    op_chk(float_alu_pkg::OP_CMP, TWO, ONE, 40'h0, 8'h00);
    op_chk(float_alu_pkg::OP_CMP, ONE, TWO, 40'h0, 8'h04);
    op_chk(float_alu_pkg::OP_CMP, ONE, ONE, 40'h0, 8'h01);
    op_chk(float_alu_pkg::OP_CMP, NAN, ONE, 40'h0, 8'h20);
    core_sequencer_model_inst.fix_cmp(1'b1);
    #1;
    hist = {1'b1, hist[7:1]};
    check({32'h0, STATUS[31:24]}, {32'h0, hist});
    op_chk(float_alu_pkg::OP_ADD, ONE, TWO, THREE, 8'h00);
    reg_rd(`STATUS_OFS, {hist, 24'h000400});
    wrap_up;
  end
endmodule

//--- pkg/float_alu_defines.svh
// Offsets, field positions, reset values and write masks of the float ALU slice.
`ifndef FLOAT_ALU_DEFINES_SVH
`define FLOAT_ALU_DEFINES_SVH
`define MODE_OFS      8'h00
`define STATUS_OFS    8'h04
`define STICKY_OFS    8'h08
`define MODE_TRUNC    0
`define MODE_NARROW   1
`define MODE_RST      32'h0000_0000
`define MODE_WMASK    32'h0000_0003
`define ST_ZERO       0
`define ST_OVF        1
`define ST_NEG        2
`define ST_CARRY      3
`define ST_INSIGN     4
`define ST_INVALID    5
`define ST_FLOAT      10
`define ST_HIST_LO    24
`define ST_HIST_HI    31
`define STATUS_RST    32'h0000_0000
`define STATUS_WMASK  32'hff00_043f
`define SK_UNDER      0
`define SK_OVF        1
`define SK_INTOVF     2
`define SK_INVALID    3
`define STICKY_RST    32'h0000_0000
`define STICKY_WMASK  32'h0000_000f
`define NARROW_GUARD  10
`define NARROW_LSB    11
`define WIDE_GUARD    2
`define WIDE_LSB      3
`define EXP_MAX       8'hff
`define EXP_NMAX      8'hfe
`define NARROW_FMAX   31'h7fff_ff00
`endif

//--- pkg/float_alu_pkg.sv
// Types shared by the float ALU slice and its users.
package float_alu_pkg;
  typedef enum logic [5:0] {
    OP_ADD  = 6'h01,
    OP_SUB  = 6'h02,
    OP_AADD = 6'h04,
    OP_ASUB = 6'h08,
    OP_HALF = 6'h10,
    OP_CMP  = 6'h20
  } op_type;
  typedef struct packed {
    op_type      op;
    logic [39:0] a;
    logic [39:0] b;
  } alu_req_type;
endpackage

//--- verilog/float_add_sub_compare_alu.sv
// Float add, subtract, absolute, halved-sum and compare slice with status registers.
`timescale 1ns/100ps
`include "float_alu_defines.svh"
// ****************************************************************
// Summary of operation
// ****************************************************************
module float_add_sub_compare_alu #(
  parameter int ADDR_W = 8
) (
  input  wire logic                      CLK,
  input  wire logic                      RST_N,
  input  wire logic                      OP_VALID,
  input  float_alu_pkg::alu_req_type     OP_REQ,
  input  wire logic                      FIX_CMP_VALID,
  input  wire logic                      FIX_CMP_GT,
  input  wire logic [ADDR_W-1:0]         ADDR,
  input  wire logic [31:0]               WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  output logic      [31:0]               RDATA,
  output logic      [39:0]               RESULT,
  output logic                           RESULT_WE,
  output logic      [31:0]               STATUS,
  output logic      [31:0]               STICKY
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Right shift that keeps every lost bit as a sticky bit in bit 0.
  function automatic logic [34:0] shr_jam(input logic [34:0] v, input logic [7:0] d);
    logic [34:0] r;
    logic        lost;
    r = '0;
    lost = 1'b0;
    if (d > 8'd34) begin
      lost = |v;
    end else begin
      r = v >> d;
      lost = |(v & ~({35{1'b1}} << d));
    end
    return {r[34:1], r[0] | lost};
  endfunction

  function automatic logic [5:0] lead_zeros(input logic [35:0] v);
    logic [5:0] n;
    logic       hit;
    n = 6'h24;
    hit = 1'b0;
    for (int i = 35; i >= 0; i--) begin
      if (v[i] && !hit) begin
        n = 6'(35 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  // ****************************************************************
  // Operand decode
  // ****************************************************************
  logic [39:0] opnd    [2];
  logic        is_nan  [2];
  logic        is_inf  [2];
  logic        is_zero [2];
  logic [38:0] mag     [2];
  logic [34:0] mant    [2];

  assign opnd[0] = OP_REQ.a;
  assign opnd[1] = OP_REQ.b;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_opnd
      assign is_nan[gi]  = (opnd[gi][38:31] == `EXP_MAX) && (|opnd[gi][30:0]);
      assign is_inf[gi]  = (opnd[gi][38:31] == `EXP_MAX) && !(|opnd[gi][30:0]);
      assign is_zero[gi] = (opnd[gi][38:31] == 8'h00);
      assign mag[gi]     = is_zero[gi] ? 39'h0 : opnd[gi][38:0];
      assign mant[gi]    = is_zero[gi] ? 35'h0 : {1'b1, opnd[gi][30:0], 3'b000};
    end
  endgenerate

  wire float_alu_pkg::op_type op = OP_REQ.op;
  wire is_sub   = (op == float_alu_pkg::OP_SUB) || (op == float_alu_pkg::OP_ASUB);
  wire is_abs   = (op == float_alu_pkg::OP_AADD) || (op == float_alu_pkg::OP_ASUB);
  wire is_half  = (op == float_alu_pkg::OP_HALF);
  wire is_cmp   = (op == float_alu_pkg::OP_CMP);
  wire do_arith = OP_VALID && !is_cmp;
  wire do_cmp   = OP_VALID && is_cmp;

  // ****************************************************************
  // Align and add
  // ****************************************************************
  logic [31:0] mode_q;
  wire         trunc  = mode_q[`MODE_TRUNC];
  wire         narrow = mode_q[`MODE_NARROW];

  wire         sg_a    = opnd[0][39];
  wire         sg_b    = opnd[1][39] ^ is_sub;
  wire         eff_sub = sg_a ^ sg_b;
  wire         a_big   = mag[0] >= mag[1];
  wire  [7:0]  exp_big = a_big ? mag[0][38:31] : mag[1][38:31];
  wire  [7:0]  exp_sml = a_big ? mag[1][38:31] : mag[0][38:31];
  wire  [34:0] m_big   = a_big ? mant[0] : mant[1];
  wire  [34:0] m_sml   = shr_jam(a_big ? mant[1] : mant[0], exp_big - exp_sml);
  wire  [35:0] sum     = eff_sub ? ({1'b0, m_big} - {1'b0, m_sml})
                                 : ({1'b0, m_big} + {1'b0, m_sml});
  wire  [5:0]  lz      = lead_zeros(sum);
  wire  [35:0] norm    = sum << lz;
  wire  [34:0] nm      = norm[35:1];
  // The half step only moves the exponent, so no mantissa precision is lost.
  wire signed [10:0] exp_pre = $signed({3'b000, exp_big}) + 11'sd1
                               - $signed({5'b00000, lz})
                               - $signed({10'h000, is_half});

  // ****************************************************************
  // Rounding
  // ****************************************************************
  wire        rnd_g   = narrow ? nm[`NARROW_GUARD] : nm[`WIDE_GUARD];
  wire        rnd_st  = (narrow ? |nm[`NARROW_GUARD-1:0] : |nm[`WIDE_GUARD-1:0]) | norm[0];
  wire        rnd_l   = narrow ? nm[`NARROW_LSB] : nm[`WIDE_LSB];
  wire [34:0] kept    = narrow ? {nm[34:`NARROW_LSB], 11'h000} : {nm[34:`WIDE_LSB], 3'b000};
  wire        rnd_inc = !trunc && rnd_g && (rnd_st || rnd_l);
  wire [35:0] rnd_add = narrow ? 36'h0_0000_0800 : 36'h0_0000_0008;
  wire [35:0] rsum    = {1'b0, kept} + (rnd_inc ? rnd_add : 36'h0);
  wire [30:0] frac_r  = rsum[35] ? 31'h0 : rsum[33:3];
  wire signed [10:0] exp_r = exp_pre + $signed({10'h000, rsum[35]});

  wire res_zero = (sum == 36'h0) || (exp_r <= 11'sd0);
  wire res_ovf  = (sum != 36'h0) && (exp_r >= 11'sd255);
  wire sign_raw = (sum == 36'h0) ? (sg_a & sg_b) : (a_big ? sg_a : sg_b);

  // ****************************************************************
  // Special cases and result
  // ****************************************************************
  wire any_nan  = is_nan[0] || is_nan[1];
  wire inf_any  = is_inf[0] || is_inf[1];
  wire inf_bad  = is_inf[0] && is_inf[1] && eff_sub;
  wire invalid  = any_nan || inf_bad;
  wire inf_sign = is_inf[0] ? sg_a : sg_b;
  wire sign_o   = !is_abs && (inf_any ? inf_sign : sign_raw);
  wire [38:0] sat_mag = !trunc ? {`EXP_MAX, 31'h0}
                      : narrow ? {`EXP_NMAX, `NARROW_FMAX}
                      : {`EXP_NMAX, 31'h7fff_ffff};
  wire [39:0] res_d = invalid  ? 40'hff_ffff_ffff
                    : inf_any  ? {sign_o, `EXP_MAX, 31'h0}
                    : res_ovf  ? {sign_o, sat_mag}
                    : res_zero ? {sign_o, 39'h0}
                    : {sign_o, exp_r[7:0], frac_r};

  wire fl_zero = !invalid && !inf_any && res_zero;
  wire fl_neg  = !invalid && !is_abs && sign_o;
  wire fl_ovf  = !invalid && !is_half && (inf_any || res_ovf);

  // ****************************************************************
  // Compare
  // ****************************************************************
  wire cmp_eq  = !any_nan && (mag[0] == mag[1])
               && ((sg_a == opnd[1][39]) || (mag[0] == 39'h0));
  wire cmp_lt  = !any_nan && !cmp_eq
               && ((sg_a && !opnd[1][39])
                || (!sg_a && !opnd[1][39] && (mag[0] < mag[1]))
                || (sg_a && opnd[1][39] && (mag[0] > mag[1])));
  wire cmp_gt  = !cmp_eq && !cmp_lt;

  // ****************************************************************
  // Register bus and status
  // ****************************************************************
  logic [31:0] status_q;
  logic [31:0] sticky_q;
  wire  mode_wr   = WR && (ADDR == ADDR_W'(`MODE_OFS));
  wire  status_wr = WR && (ADDR == ADDR_W'(`STATUS_OFS));
  wire  sticky_wr = WR && (ADDR == ADDR_W'(`STICKY_OFS));

  wire        f_zero = do_cmp ? cmp_eq : fl_zero;
  wire        f_neg  = do_cmp ? cmp_lt : fl_neg;
  wire        f_ovf  = !do_cmp && fl_ovf;
  wire        f_inv  = do_cmp ? any_nan : invalid;
  wire [7:0]  hist   = status_q[`ST_HIST_HI:`ST_HIST_LO];
  wire [7:0]  hist_d = do_cmp ? {cmp_gt, hist[7:1]}
                     : FIX_CMP_VALID ? {FIX_CMP_GT, hist[7:1]}
                     : hist;
  wire [31:0] st_base = status_wr ? (WDATA & `STATUS_WMASK) : status_q;
  // An operation overrides the flag fields a software write would load.
  wire [31:0] st_ops  = {8'h00, 13'h0000, 1'b1, 4'h0, f_inv, 1'b0, 1'b0,
                         f_neg, f_ovf, f_zero};
  wire [31:0] st_flag = OP_VALID ? st_ops : {8'h00, st_base[23:0]};
  wire [31:0] status_d = {(do_cmp || FIX_CMP_VALID) ? hist_d : st_base[31:24],
                          st_flag[23:0]};

  // A flag set in the same cycle as a software clear survives.
  wire [31:0] sk_base = sticky_wr ? (WDATA & `STICKY_WMASK) : sticky_q;
  wire [31:0] sk_set  = {28'h0, OP_VALID && f_inv, 1'b0,
                         do_arith && !is_half && fl_ovf,
                         do_arith && fl_zero};
  wire [31:0] sticky_d = sk_base | sk_set;

  wire [31:0] rd_mux = (ADDR == ADDR_W'(`MODE_OFS))   ? mode_q
                     : (ADDR == ADDR_W'(`STATUS_OFS)) ? status_q
                     : (ADDR == ADDR_W'(`STICKY_OFS)) ? sticky_q
                     : 32'h0000_0000;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q   <= `MODE_RST;
      status_q <= `STATUS_RST;
      sticky_q <= `STICKY_RST;
    end else begin
      mode_q   <= mode_wr ? (WDATA & `MODE_WMASK) : mode_q;
      status_q <= status_d;
      sticky_q <= sticky_d;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA     <= 32'h0000_0000;
      RESULT    <= 40'h00_0000_0000;
      RESULT_WE <= 1'b0;
    end else begin
      RDATA     <= RD ? rd_mux : 32'h0000_0000;
      RESULT    <= do_arith ? res_d : RESULT;
      RESULT_WE <= do_arith;
    end
  end

  assign STATUS = status_q;
  assign STICKY = sticky_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_cmp_issue;
    OP_VALID && is_cmp;
  endsequence

  sequence s_nan_arith;
    OP_VALID && !is_cmp && any_nan;
  endsequence

  a_nan_all_ones: assert property (s_nan_arith |=> RESULT_WE && (&RESULT)
                                   && STATUS[`ST_INVALID])
    else $error("Not-a-number input did not give all ones.");
  a_cmp_no_write: assert property (s_cmp_issue |=> !RESULT_WE)
    else $error("Compare wrote a destination.");
  a_hist_shift: assert property (s_cmp_issue |=>
                  STATUS[30:24] == $past(STATUS[31:25]))
    else $error("History did not shift on compare.");
  a_hist_hold: assert property (!OP_VALID && !FIX_CMP_VALID && !status_wr
                  |=> $stable(STATUS[31:24]))
    else $error("History moved without a compare.");
  a_half_no_ovf: assert property (OP_VALID && is_half |=> !STATUS[`ST_OVF])
    else $error("Halved sum raised overflow.");
  a_abs_positive: assert property (OP_VALID && is_abs && !invalid |=>
                    !RESULT[39] && !STATUS[`ST_NEG])
    else $error("Absolute form gave a negative result.");
  a_zero_result: assert property (OP_VALID && !is_cmp ##1 STATUS[`ST_ZERO]
                   |-> RESULT[38:0] == 39'h0)
    else $error("Zero flag with nonzero result.");
  a_float_flag: assert property (OP_VALID |=> STATUS[`ST_FLOAT]
                  && !STATUS[`ST_CARRY] && !STATUS[`ST_INSIGN])
    else $error("Float flag or cleared flags wrong.");
  a_sticky_inv: assert property (OP_VALID && f_inv |=> STICKY[`SK_INVALID]
                  ##1 (STICKY[`SK_INVALID] || $past(sticky_wr)))
    else $error("Sticky invalid not held.");
  a_narrow_low: assert property (OP_VALID && !is_cmp && narrow && !invalid
                  |=> RESULT[7:0] == 8'h00)
    else $error("Narrow rounding left low bits set.");
  a_read_latency: assert property (RD && ADDR == ADDR_W'(`MODE_OFS) && !WR
                    |=> RDATA == $past(mode_q))
    else $error("Mode read back wrong.");

  // ****************************************************************
  // Result and flag assertions
  // ****************************************************************
  // Finite arithmetic with no special operand, where the datapath result is used.
  sequence s_arith_fin;
    do_arith && !invalid && !inf_any;
  endsequence

  // The invalid cases bypass rounding entirely, so they are guarded apart.
  sequence s_arith_bad;
    do_arith && invalid;
  endsequence

  a_result_pulse: assert property (do_arith |=> RESULT_WE)
    else $error("Arithmetic did not write its result.");
  a_result_hold: assert property (!do_arith |=> $stable(RESULT))
    else $error("Result changed without an arithmetic op.");
  a_inf_clash: assert property (do_arith && inf_bad
                 |=> STATUS[`ST_INVALID] && (&RESULT))
    else $error("Clashing infinities not flagged invalid.");
  a_inv_flag: assert property (OP_VALID && any_nan
                |=> STATUS[`ST_INVALID])
    else $error("Not-a-number input not flagged invalid.");
  a_bad_no_neg: assert property (s_arith_bad |=> !STATUS[`ST_NEG])
    else $error("Invalid result flagged negative.");
  a_abs_no_neg: assert property (do_arith && is_abs |=> !STATUS[`ST_NEG])
    else $error("Absolute form flagged negative.");
  a_sat_trunc: assert property (s_arith_fin ##0 res_ovf && trunc
                 |=> RESULT[38:31] == `EXP_NMAX)
    else $error("Truncated overflow did not saturate to largest normal.");
  a_sat_near: assert property (s_arith_fin ##0 res_ovf && !trunc
                |=> RESULT[38:0] == {`EXP_MAX, 31'h0})
    else $error("Rounded overflow did not give infinity.");
  a_abs_under: assert property (s_arith_fin ##0 is_abs && res_zero
                 |=> RESULT == 40'h00_0000_0000)
    else $error("Absolute underflow did not give positive zero.");
  a_denorm_in: assert property (do_arith && is_zero[0] && is_zero[1]
                 |=> RESULT[38:0] == 39'h0 && STATUS[`ST_ZERO])
    else $error("Denormal inputs not flushed to zero.");
  a_ovf_flag: assert property (s_arith_fin ##0 res_ovf && !is_half
                |=> STATUS[`ST_OVF])
    else $error("Overflow flag missing.");
  a_sticky_ovf: assert property (do_arith && !is_half && fl_ovf
                  |=> STICKY[`SK_OVF])
    else $error("Sticky overflow not set.");
  a_half_sticky: assert property (do_arith && is_half && !sticky_wr
                   |=> STICKY[`SK_OVF] == $past(sticky_q[`SK_OVF]))
    else $error("Halved sum changed sticky overflow.");
  a_sticky_under: assert property (do_arith && fl_zero
                    |=> STICKY[`SK_UNDER])
    else $error("Sticky underflow not set.");
  a_intovf_keep: assert property (!sticky_wr
                   |=> STICKY[`SK_INTOVF] == $past(sticky_q[`SK_INTOVF]))
    else $error("Integer overflow sticky moved by an operation.");

  // ****************************************************************
  // Compare and read-back assertions
  // ****************************************************************
  // The newest history bit must agree with the flags of the same compare.
  a_cmp_gt_bit: assert property (s_cmp_issue
                  |=> STATUS[31] == !(STATUS[`ST_ZERO] || STATUS[`ST_NEG]))
    else $error("Newest history bit disagrees with compare flags.");
  a_cmp_clears: assert property (s_cmp_issue |=> !STATUS[`ST_OVF]
                  && !STATUS[`ST_CARRY] && !STATUS[`ST_INSIGN])
    else $error("Compare left a cleared flag set.");
  a_cmp_equal: assert property (do_cmp && !any_nan && mag[0] == mag[1]
                 && sg_a == opnd[1][39] |=> STATUS[`ST_ZERO] && !STATUS[`ST_NEG])
    else $error("Equal operands not flagged equal.");
  a_cmp_sticky: assert property (do_cmp && any_nan |=> STICKY[`SK_INVALID])
    else $error("Compare on not-a-number did not set sticky invalid.");
  a_fix_shift: assert property (FIX_CMP_VALID && !do_cmp
                 |=> STATUS[31] == $past(FIX_CMP_GT))
    else $error("Fixed compare did not enter the history.");
  a_fix_order: assert property (FIX_CMP_VALID && !do_cmp
                 |=> STATUS[30:24] == $past(status_q[31:25]))
    else $error("Fixed compare did not shift the history.");
  a_status_read: assert property (RD && ADDR == ADDR_W'(`STATUS_OFS) && !WR
                   |=> RDATA == $past(status_q))
    else $error("Status read back wrong.");
  a_read_idle: assert property (!RD |=> RDATA == 32'h0000_0000)
    else $error("Read data stood outside its cycle.");

endmodule
